// file: src/ssm_pin_if.sv
// Purpose: carries raw and synchronised pin levels
// Assumes: one clock domain on the synchronised side
// Notes: raw side is asynchronous to core_clk
`timescale 1ns/1ps
interface ssm_pin_if #(parameter int W = 17);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sync_end (input raw, output sync);
    modport user_end (output raw, input sync);
endinterface

// file: src/ssm_pkg.sv
// Purpose: constants and types of the servo status / monitor select block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: status display bit n sits at word index n-1
//
// Contract
// - status A bit 1 follows fault flag
// - status A bit 2 during dynamic braking
// - status A bit 3 = setup bit 0
// - status A bit 4: speed at/above detect
// - status A bit 5: in-position or speed-match
// - status A bit 6 during proportional-only control
// - status A bits 7, 8 mirror limit inputs
// - status A bit 9 while motor energised
// - bits 10-15 mirror encoder and pole phases; pole bits 13-15 read zero with absolute encoders
// - status A bit 16 while run input on
// - status A bit 17 mirrors multi-function input
// - bits 18, 19 mirror drive inhibit inputs
// - status A bit 20: sensor-on, absolute encoders
// - status B bits 1-3: pulses, counter clear
// - status B bit 4 while torque clamped
// - status B bit 5 brake, bit 7 power
// - status B bit 6 clears at 20% overload
// - status B bit 8 error after power; 9-20 zero
// - aux monitor: current, command or zero
// - speed monitor: speed, deviation or zero
// - deviation scale x1/x100, latched at power-up
package ssm_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_STAT_A = 8'h04;
    localparam logic [7:0] ADDR_STAT_B = 8'h08;
    localparam logic [7:0] ADDR_ROT_SPD = 8'h0C;
    localparam logic [7:0] ADDR_INPOS = 8'h10;
    localparam logic [7:0] ADDR_SPD_BAND = 8'h14;
    localparam logic [15:0] RST_SETUP = 16'h0000;
    localparam logic [15:0] RST_ROT_SPD = 16'h0014;
    localparam logic [15:0] RST_INPOS = 16'h0003;
    localparam logic [15:0] RST_SPD_BAND = 16'h000A;
    // ---------------------------------------------------------------
    // setup word fields
    // ---------------------------------------------------------------
    localparam int SU_REVERSE = 0;
    localparam int SU_AUX_SEL = 6;
    localparam int SU_SPD_SEL = 7;
    localparam int SU_DEV_X100 = 14;
    localparam int DEV_SCALE = 100;
    localparam int OVL_WARN_PCT = 20;
    localparam int OVL_FULL_PCT = 100;
    // ---------------------------------------------------------------
    // pin input indices
    // ---------------------------------------------------------------
    localparam int PIN_FWD_SEL1 = 0;
    localparam int PIN_REV_SEL2 = 1;
    localparam int PIN_RUN = 2;
    localparam int PIN_MULTI = 3;
    localparam int PIN_FWD_INH = 4;
    localparam int PIN_REV_INH = 5;
    localparam int PIN_SENSOR = 6;
    localparam int PIN_CW = 7;
    localparam int PIN_CCW = 8;
    localparam int PIN_ECLR = 9;
    localparam int PIN_ENC_A = 10;
    localparam int PIN_ENC_B = 11;
    localparam int PIN_ENC_Z = 12;
    localparam int PIN_POLE_U = 13;
    localparam int PIN_POLE_V = 14;
    localparam int PIN_POLE_W = 15;
    localparam int PIN_MAIN_PWR = 16;
    localparam int PIN_COUNT = 17;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CM_POSITION = 2'h0,
        CM_SPEED = 2'h1,
        CM_TORQUE = 2'h2
    } ssm_mode_e;
    typedef enum logic [1:0] {
        PH_LOAD = 2'h0,
        PH_RUN = 2'h1
    } ssm_phase_e;
endpackage

// file: src/ssm_sync.sv
// Purpose: two-flop synchroniser for drive pin inputs
// Assumes: inputs are quasi-static levels
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module ssm_sync #(
    parameter int W = 17
) (
    input wire logic core_clk,
    input wire logic rst_b,
    ssm_pin_if.sync_end pins
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= pins.raw;
            stable_q <= meta_q;
        end
    end

    assign pins.sync = stable_q;
endmodule

// file: src/ssm_top.sv
// Purpose: servo status words and analog monitor source select
// Assumes: loop quantities arrive on core_clk; pins are asynchronous
// Notes: registers reached over AHB-Lite, zero wait states
`timescale 1ns/1ps
module ssm_top #(
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // power-up copy of the setup word
    input wire logic [15:0] setupInit,
    // loop signals, same clock
    input wire logic faultFlag,
    input wire logic dynBrakeActive,
    input wire logic propControlActive,
    input wire logic motorEnergised,
    input wire logic torqueClamped,
    input wire logic brakeInterlock,
    input wire logic absEncoder,
    input wire logic [1:0] ctrlMode,
    input wire logic signed [DW-1:0] motorSpeed,
    input wire logic signed [DW-1:0] speedCmd,
    input wire logic signed [DW-1:0] pulseSpeed,
    input wire logic signed [DW-1:0] motorCurrent,
    input wire logic signed [DW-1:0] devCount,
    input wire logic [DW-1:0] overloadAccum,
    input wire logic [DW-1:0] overloadLevel,
    // drive pins, asynchronous
    input wire logic fwdLimitSel1,
    input wire logic revLimitSel2,
    input wire logic runCmd,
    input wire logic multiFunctionInput,
    input wire logic fwdInhibit,
    input wire logic revInhibit,
    input wire logic absEncoderEnableIn,
    input wire logic cwPulse,
    input wire logic ccwPulse,
    input wire logic errCountClear,
    input wire logic encA,
    input wire logic encB,
    input wire logic encZ,
    input wire logic poleU,
    input wire logic poleV,
    input wire logic poleW,
    input wire logic mainPowerPresent,
    // display and monitor outputs
    output logic [19:0] statusWordA,
    output logic [19:0] statusWordB,
    output logic signed [DW-1:0] auxMonitorOut,
    output logic signed [DW-1:0] speedMonitorOut
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        ssm_pkg::ssm_phase_e phase;
        logic devX100;
        logic [15:0] setup;
        logic [15:0] rotSpd;
        logic [15:0] inPosBand;
        logic [15:0] spdBand;
        logic [19:0] statA;
        logic [19:0] statB;
        logic signed [DW-1:0] auxMon;
        logic signed [DW-1:0] spdMon;
        // bus side
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] rdData;
    } ssm_state_s;

    ssm_state_s st_q;
    ssm_state_s st_d;

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    ssm_pin_if #(.W(ssm_pkg::PIN_COUNT)) pinBus ();

    assign pinBus.raw = {
        mainPowerPresent,
        poleW,
        poleV,
        poleU,
        encZ,
        encB,
        encA,
        errCountClear,
        ccwPulse,
        cwPulse,
        absEncoderEnableIn,
        revInhibit,
        fwdInhibit,
        multiFunctionInput,
        runCmd,
        revLimitSel2,
        fwdLimitSel1
    };

    // pins are levels: a pulse shorter than a clock may be missed
    ssm_sync #(.W(ssm_pkg::PIN_COUNT)) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pins(pinBus.sync_end)
    );

    logic [ssm_pkg::PIN_COUNT-1:0] pin;
    assign pin = pinBus.sync;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // one spare bit so the most negative value keeps its magnitude
    function automatic logic [DW:0] absVal(input logic signed [DW:0] v);
        absVal = v[DW] ? (-v) : v;
    endfunction

    function automatic logic signed [DW:0] ext(input logic signed [DW-1:0] v);
        ext = {v[DW-1], v};
    endfunction

    logic [DW:0] spdMag;
    logic [DW:0] devMag;
    logic [DW:0] spdErr;

    logic atSpeed;
    logic inPos;
    logic spdMatch;
    logic bit5;

    logic [DW+7:0] ovlScaled;
    logic [DW+7:0] ovlLimit;
    logic ovlWarn;

    logic isPos;
    logic isSpd;
    logic isTrq;

    logic signed [DW-1:0] devShown;

    assign isPos = (ctrlMode == ssm_pkg::CM_POSITION);
    assign isSpd = (ctrlMode == ssm_pkg::CM_SPEED);
    assign isTrq = (ctrlMode == ssm_pkg::CM_TORQUE);

    assign spdMag = absVal(ext(motorSpeed));
    assign devMag = absVal(ext(devCount));
    assign spdErr = absVal(ext(motorSpeed) - ext(speedCmd));

    // rotation detected at or above threshold
    assign atSpeed = (spdMag >= {1'h0, st_q.rotSpd});
    assign inPos = (devMag <= {1'h0, st_q.inPosBand});
    assign spdMatch = (spdErr <= {1'h0, st_q.spdBand});
    // one lamp, meaning picked by control mode
    // mode 11 counts as neither: the lamp shows speed match
    assign bit5 = isPos ? inPos : spdMatch;

    // warning lamp is lit below the 20% mark, off once reached
    // widened so the percent products never wrap
    assign ovlScaled = (DW+8)'(overloadAccum)
        * (DW+8)'(ssm_pkg::OVL_FULL_PCT);
    assign ovlLimit = (DW+8)'(overloadLevel)
        * (DW+8)'(ssm_pkg::OVL_WARN_PCT);
    assign ovlWarn = !(ovlScaled >= ovlLimit);

    // x100 scale uses the power-up latched bit, never the live one
    assign devShown = st_q.devX100
        ? DW'(devCount / DW'(ssm_pkg::DEV_SCALE))
        : devCount;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic addrTaken;
    logic [7:0] aOff;
    logic [31:0] rdMux;

    // hsize is ignored: only whole-word accesses are expected
    assign addrTaken = hsel && htrans[1] && hready;
    assign aOff = haddr[7:0];

    // reserved bits and unmapped offsets read as zero
    always_comb begin
        case (aOff)
            ssm_pkg::ADDR_SETUP: rdMux = {16'h0000, st_q.setup};
            ssm_pkg::ADDR_STAT_A: rdMux = {12'h000, st_q.statA};
            ssm_pkg::ADDR_STAT_B: rdMux = {12'h000, st_q.statB};
            ssm_pkg::ADDR_ROT_SPD: rdMux = {16'h0000, st_q.rotSpd};
            ssm_pkg::ADDR_INPOS: rdMux = {16'h0000, st_q.inPosBand};
            ssm_pkg::ADDR_SPD_BAND: rdMux = {16'h0000, st_q.spdBand};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // power-up: take the stored setup word, freeze the scale bit
        case (st_q.phase)
            ssm_pkg::PH_LOAD: begin
                st_d.setup = setupInit;
                st_d.devX100 = setupInit[ssm_pkg::SU_DEV_X100];
                st_d.phase = ssm_pkg::PH_RUN;
            end
            ssm_pkg::PH_RUN: begin
                st_d.phase = ssm_pkg::PH_RUN;
            end
            default: begin
                st_d.phase = ssm_pkg::PH_LOAD;
            end
        endcase

        // write lands at the end of its data phase
        st_d.wrPend = 1'h0;
        if (st_q.wrPend) begin
            case (st_q.wrAddr)
                ssm_pkg::ADDR_SETUP: st_d.setup = hwdata[15:0];
                ssm_pkg::ADDR_ROT_SPD: st_d.rotSpd = hwdata[15:0];
                ssm_pkg::ADDR_INPOS: st_d.inPosBand = hwdata[15:0];
                ssm_pkg::ADDR_SPD_BAND: st_d.spdBand = hwdata[15:0];
                default: st_d.wrPend = 1'h0;
            endcase
        end
        if (addrTaken) begin
            st_d.wrPend = hwrite;
            st_d.wrAddr = aOff;
            st_d.rdData = hwrite ? 32'h0000_0000 : rdMux;
        end

        // whole words sampled in one edge
        st_d.statA = 20'h0_0000;
        st_d.statA[0] = faultFlag;
        st_d.statA[1] = dynBrakeActive;
        st_d.statA[2] = st_q.setup[ssm_pkg::SU_REVERSE];
        st_d.statA[3] = atSpeed;
        st_d.statA[4] = bit5;
        st_d.statA[5] = propControlActive;

        // pin bits trail loop bits by the two sync stages
        st_d.statA[6] = pin[ssm_pkg::PIN_FWD_SEL1];
        st_d.statA[7] = pin[ssm_pkg::PIN_REV_SEL2];
        st_d.statA[8] = motorEnergised;

        st_d.statA[9] = pin[ssm_pkg::PIN_ENC_A];
        st_d.statA[10] = pin[ssm_pkg::PIN_ENC_B];
        st_d.statA[11] = pin[ssm_pkg::PIN_ENC_Z];

        // pole sensors exist on incremental encoders only
        st_d.statA[12] = !absEncoder && pin[ssm_pkg::PIN_POLE_U];
        st_d.statA[13] = !absEncoder && pin[ssm_pkg::PIN_POLE_V];
        st_d.statA[14] = !absEncoder && pin[ssm_pkg::PIN_POLE_W];

        st_d.statA[15] = pin[ssm_pkg::PIN_RUN];
        st_d.statA[16] = pin[ssm_pkg::PIN_MULTI];
        st_d.statA[17] = pin[ssm_pkg::PIN_FWD_INH];
        st_d.statA[18] = pin[ssm_pkg::PIN_REV_INH];
        st_d.statA[19] = absEncoder && pin[ssm_pkg::PIN_SENSOR];

        st_d.statB = 20'h0_0000;
        st_d.statB[0] = pin[ssm_pkg::PIN_CW];
        st_d.statB[1] = pin[ssm_pkg::PIN_CCW];
        st_d.statB[2] = pin[ssm_pkg::PIN_ECLR];

        st_d.statB[3] = torqueClamped;
        st_d.statB[4] = brakeInterlock;
        st_d.statB[5] = ovlWarn;

        st_d.statB[6] = pin[ssm_pkg::PIN_MAIN_PWR];
        // a fault only counts once main power is up
        st_d.statB[7] = faultFlag && pin[ssm_pkg::PIN_MAIN_PWR];

        // aux monitor select
        if (!st_q.setup[ssm_pkg::SU_AUX_SEL]) begin
            st_d.auxMon = motorCurrent;
        end else if (isTrq) begin
            st_d.auxMon = '0;
        end else if (isSpd) begin
            st_d.auxMon = speedCmd;
        end else begin
            st_d.auxMon = pulseSpeed;
        end

        // speed monitor select
        // deviation only means something under position control
        if (!st_q.setup[ssm_pkg::SU_SPD_SEL]) begin
            st_d.spdMon = motorSpeed;
        end else if (isPos) begin
            st_d.spdMon = devShown;
        end else begin
            st_d.spdMon = '0;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.phase <= ssm_pkg::PH_LOAD;
            st_q.devX100 <= 1'h0;
            st_q.setup <= ssm_pkg::RST_SETUP;
            st_q.rotSpd <= ssm_pkg::RST_ROT_SPD;
            st_q.inPosBand <= ssm_pkg::RST_INPOS;
            st_q.spdBand <= ssm_pkg::RST_SPD_BAND;
            st_q.statA <= 20'h0_0000;
            st_q.statB <= 20'h0_0000;
            st_q.auxMon <= '0;
            st_q.spdMon <= '0;
            // bus side
            st_q.wrPend <= 1'h0;
            st_q.wrAddr <= 8'h00;
            st_q.rdData <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // no wait states: every access finishes in its first data cycle
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = st_q.rdData;

    assign statusWordA = st_q.statA;
    assign statusWordB = st_q.statB;
    assign auxMonitorOut = st_q.auxMon;
    assign speedMonitorOut = st_q.spdMon;
endmodule

// file: verif/ssm_drive_model.sv
// Purpose: stand-in for the drive loops and pins around the status block
// Assumes: the bench asks for levels one edge ahead
// Notes: levels change just after an edge, like quasi-static pins
`timescale 1ns/1ps
module ssm_drive_model (
    input wire logic core_clk,
    input wire logic [23:0] want,
    output logic [23:0] lvl = 24'h00_0000
);
    // nonblocking copy on the edge, so every pin moves on a sampling edge and the block samples its old level there
    always @(posedge core_clk) lvl <= want;
endmodule

// file: verif/ssm_monitor.sv
// Purpose: concurrent checks on status words and monitor outputs
// Assumes: pins pass two sync stages plus one output register
// Notes: upQ skips edges whose history predates reset release
`timescale 1ns/1ps
module ssm_monitor #(
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic faultFlag,
    input wire logic [1:0] ctrlMode,
    input wire logic signed [DW-1:0] motorSpeed,
    input wire logic signed [DW-1:0] motorCurrent,
    input wire logic [DW-1:0] overloadAccum,
    input wire logic [DW-1:0] overloadLevel,
    input wire logic fwdLimitSel1,
    input wire logic revLimitSel2,
    input wire logic runCmd,
    input wire logic fwdInhibit,
    input wire logic revInhibit,
    input wire logic [19:0] statusWordA,
    input wire logic [19:0] statusWordB,
    input wire logic signed [DW-1:0] auxMonitorOut,
    input wire logic signed [DW-1:0] speedMonitorOut
);
    // ---------------------------------------------------------------
    // history guard
    // ---------------------------------------------------------------
    logic [2:0] upQ;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) upQ <= 3'h0;
        else if (upQ != 3'h7) upQ <= upQ + 3'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    AST_FAULT_BIT: assert property (upQ != 3'h0 |-> statusWordA[0] == $past(faultFlag))
        else $error("fault bit does not follow fault flag");
    AST_LIMIT_PINS: assert property (upQ > 3'h4 |->
        statusWordA[7:6] == $past({revLimitSel2, fwdLimitSel1}, 3))
        else $error("limit select bits wrong");
    AST_RUN_PIN: assert property ($rose(runCmd) && upQ > 3'h4 ##1 $stable(runCmd) [*2]
        |=> statusWordA[15])
        else $error("run bit not set three edges after run input");
    AST_INHIBIT: assert property (upQ > 3'h4 |->
        statusWordA[18:17] == $past({revInhibit, fwdInhibit}, 3))
        else $error("inhibit bits wrong");
    AST_B_UNUSED: assert property (statusWordB[19:8] == 12'h000)
        else $error("unused status bits lit");
    AST_READY_FAULT: assert property (statusWordB[7] |-> $past(faultFlag))
        else $error("error-after-power bit without fault");
    AST_OVERLOAD: assert property (upQ != 3'h0 |-> statusWordB[5] ==
        (int'($past(overloadAccum)) * 100 < int'($past(overloadLevel)) * 20))
        else $error("overload warning wrong");
    AST_AUX_TORQUE: assert property ($past(ctrlMode) == ssm_pkg::CM_TORQUE && upQ != 3'h0
        |-> auxMonitorOut == '0 || auxMonitorOut == $past(motorCurrent))
        else $error("aux monitor not zero in torque control");
    AST_SPD_MON: assert property ($past(ctrlMode) != ssm_pkg::CM_POSITION && upQ != 3'h0
        |-> speedMonitorOut == '0 || speedMonitorOut == $past(motorSpeed))
        else $error("speed monitor shows deviation outside position control");
endmodule
bind ssm_top ssm_monitor #(.DW(DW)) u_mon (
    .core_clk, .rst_b, .faultFlag, .ctrlMode, .motorSpeed, .motorCurrent, .overloadAccum,
    .overloadLevel, .fwdLimitSel1, .revLimitSel2, .runCmd, .fwdInhibit, .revInhibit,
    .statusWordA, .statusWordB, .auxMonitorOut, .speedMonitorOut
);

// file: verif/ssm_top_bench.sv
// Purpose: register and status checks of the status/monitor block
// Assumes: thresholds stay at reset values outside the register test
// Notes: w[16:0] are pins in package order, w[23:17] loop flags
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) bad(g, e); end
module ssm_top_bench;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [19:0] stA, stB;
    logic signed [15:0] aux, spdMon;
    logic [15:0] setupInit = 16'h0000;
    logic [15:0] setupQ = 16'h0000;
    logic x100 = 1'h0;
    logic [23:0] want = 24'h00_0000;
    logic [23:0] w;
    logic [1:0] ctrlMode = 2'h0;
    logic signed [15:0] motorSpeed = 16'h0000, speedCmd = 16'h0000, pulseSpeed = 16'h0000;
    logic signed [15:0] motorCurrent = 16'h0000, devCount = 16'h0000;
    logic [15:0] overloadAccum = 16'h0000;
    logic [15:0] overloadLevel = 16'h0064;
    int nMismatch = 0;
    int totalChecks = 0;
    int spd[4] = '{19, 20, -20, -19};
    int cmd[4] = '{9, 30, 10, -9};
    int dev[4] = '{3, 4, -3, -4};
    int acc[4] = '{19, 20, 21, 0};
    logic [15:0] su[4] = '{16'h0000, 16'h0041, 16'h0080, 16'h00C1};
    logic [7:0] ra[3] = '{ssm_pkg::ADDR_ROT_SPD, ssm_pkg::ADDR_INPOS, ssm_pkg::ADDR_SPD_BAND};
    logic [15:0] rv[3] = '{ssm_pkg::RST_ROT_SPD, ssm_pkg::RST_INPOS, ssm_pkg::RST_SPD_BAND};
    always #2.5 core_clk = ~core_clk;
    ssm_drive_model u_drv (.core_clk, .want, .lvl(w));
    ssm_top #(.DW(16)) u_dut (
        .core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .setupInit,
        .faultFlag(w[17]), .dynBrakeActive(w[18]), .propControlActive(w[19]),
        .motorEnergised(w[20]), .torqueClamped(w[21]), .brakeInterlock(w[22]),
        .absEncoder(w[23]), .ctrlMode, .motorSpeed, .speedCmd, .pulseSpeed, .motorCurrent,
        .devCount, .overloadAccum, .overloadLevel,
        .fwdLimitSel1(w[0]), .revLimitSel2(w[1]), .runCmd(w[2]), .multiFunctionInput(w[3]),
        .fwdInhibit(w[4]), .revInhibit(w[5]), .absEncoderEnableIn(w[6]), .cwPulse(w[7]),
        .ccwPulse(w[8]), .errCountClear(w[9]), .encA(w[10]), .encB(w[11]), .encZ(w[12]),
        .poleU(w[13]), .poleV(w[14]), .poleW(w[15]), .mainPowerPresent(w[16]),
        .statusWordA(stA), .statusWordB(stB), .auxMonitorOut(aux), .speedMonitorOut(spdMon)
    );
    // ---------------------------------------------------------------
    // expectations
    // ---------------------------------------------------------------
    function automatic int ab(int v);
        return v < 0 ? -v : v;
    endfunction
    function automatic logic [19:0] eA();
        logic [19:0] r;
        r = {w[6] & w[23], w[5:2], w[23] ? 3'h0 : w[15:13], w[12:10], w[20], w[1:0], w[19],
            2'h0, setupQ[0], w[18:17]};
        r[3] = ab(motorSpeed) >= int'(ssm_pkg::RST_ROT_SPD);
        r[4] = ctrlMode == ssm_pkg::CM_POSITION ? ab(devCount) <= int'(ssm_pkg::RST_INPOS)
            : ab(int'(motorSpeed) - int'(speedCmd)) <= int'(ssm_pkg::RST_SPD_BAND);
        return r;
    endfunction
    function automatic logic [19:0] eB();
        logic ow;
        ow = int'(overloadAccum) * ssm_pkg::OVL_FULL_PCT
            < int'(overloadLevel) * ssm_pkg::OVL_WARN_PCT;
        return {12'h000, w[17] & w[16], w[16], ow, w[22], w[21], w[9:7]};
    endfunction
    function automatic logic signed [15:0] eAux();
        if (!setupQ[6]) return motorCurrent;
        if (ctrlMode == ssm_pkg::CM_TORQUE) return 16'h0000;
        return ctrlMode == ssm_pkg::CM_SPEED ? speedCmd : pulseSpeed;
    endfunction
    function automatic logic signed [15:0] eSpd();
        int d;
        d = devCount;
        if (!setupQ[7]) return motorSpeed;
        if (ctrlMode != ssm_pkg::CM_POSITION) return 16'h0000;
        return 16'(x100 ? d / ssm_pkg::DEV_SCALE : d);
    endfunction
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        nMismatch++;
        $display("BAD %0t got %h want %h", $time, g, e);
    endtask
    // bounded wait for hready at a rising edge
    task automatic rdy();
        for (int n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (hreadyout === 1'h1) return;
        end
        nMismatch++;
        end_of_test();
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        rdy();
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0000_0000, r);
        `CHK(r, e)
        `CHK(hresp, 1'h0)
    endtask
    task automatic wrSet(input logic [15:0] v);
        wr(ssm_pkg::ADDR_SETUP, {16'h0000, v});
        setupQ = v;
    endtask
    // a reset stands in for the power cycle that latches the scale bit
    task automatic doReset(input logic [15:0] init);
        rst_b <= 1'h0;
        setupInit <= init;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'h1;
        setupQ = init;
        x100 = init[14];
        repeat (2) @(posedge core_clk);
    endtask
    // six edges cover the model, two sync stages and the output register
    task automatic settle();
        repeat (6) @(posedge core_clk);
        #1;
        `CHK(stA, eA())
        `CHK(stB, eB())
        `CHK(aux, eAux())
        `CHK(spdMon, eSpd())
        @(posedge core_clk);
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        doReset(16'h0000);
        rdchk(ssm_pkg::ADDR_SETUP, 32'h0000_0000);
        wr(8'h18, 32'hFFFF_FFFF);
        rdchk(8'h18, 32'h0000_0000);
        wr(ssm_pkg::ADDR_STAT_A, 32'hFFFF_FFFF);
        rdchk(ssm_pkg::ADDR_STAT_A, {12'h000, eA()});
        rdchk(ssm_pkg::ADDR_STAT_B, {12'h000, eB()});
        for (int i = 0; i < 3; i++) begin
            rdchk(ra[i], {16'h0000, rv[i]});
            wr(ra[i], 32'hFFFF_00FF);
            rdchk(ra[i], 32'h0000_00FF);
            wr(ra[i], {16'h0000, rv[i]});
        end
        $display("done registers");
        for (int i = 0; i < 26; i++) begin
            want <= i < 24 ? 24'h00_0001 << i : (i == 24 ? 24'hFF_FFFF : 24'h7F_FFFF);
            settle();
        end
        want <= 24'h00_0000;
        $display("done status bits");
        for (int s = 0; s < 4; s++) begin
            wrSet(su[s]);
            for (int m = 0; m < 4; m++) begin
                for (int k = 0; k < 4; k++) begin
                    ctrlMode <= 2'(m);
                    motorSpeed <= 16'(spd[k]);
                    speedCmd <= 16'(cmd[k]);
                    pulseSpeed <= 16'(cmd[k] + 7);
                    motorCurrent <= 16'(-spd[k] * 3);
                    devCount <= 16'(dev[k]);
                    overloadAccum <= 16'(acc[k]);
                    settle();
                end
            end
        end
        $display("done thresholds and monitors");
        doReset(16'h4080);
        rdchk(ssm_pkg::ADDR_SETUP, 32'h0000_4080);
        ctrlMode <= ssm_pkg::CM_POSITION;
        devCount <= 16'(-250);
        settle();
        wrSet(16'h0080);
        settle();
        doReset(16'h0080);
        settle();
        $display("done deviation scale");
        end_of_test();
    end
endmodule
